// *** src/mcc_pkg.sv ***
package mcc_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_CLK_CTRL_STATUS = 8'h2c;
  localparam logic [7:0] IDX_BEEP_CONTROL    = 8'h2d;
  localparam logic [7:0] IDX_IRQ_STATUS      = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK        = 8'h31;
  localparam logic [9:0] ADDR_CLK_CTRL_STATUS = {IDX_CLK_CTRL_STATUS, 2'b00};
  localparam logic [9:0] ADDR_BEEP_CONTROL    = {IDX_BEEP_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS      = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK        = {IDX_IRQ_MASK, 2'b00};

  // clock_control_status and beep control field positions
  localparam int CCS_CLOCK_OUTPUT_SELECT = 7;
  localparam int CCS_SLOW_PRESCALER_LO   = 5;
  localparam int CCS_SLOW_MODE_SELECT    = 4;
  localparam int CCS_TIME_BASE_LO        = 2;
  localparam int CCS_OSC_INT_ENABLE      = 1;
  localparam int CCS_OSC_TIMEOUT_FLAG    = 0;
  localparam int BEEP_TONE_LO            = 0;

  // interrupt status / mask bit positions
  localparam int IRQ_TIME_BASE = 0;
  localparam int IRQ_WAKE      = 1;

  localparam logic [7:0] CCS_RESET  = 8'h00;
  localparam logic [1:0] BEEP_RESET = 2'h0;

  // time-base periods in oscillator cycles
  localparam int unsigned TB_PERIOD_00 = 16000;
  localparam int unsigned TB_PERIOD_01 = 32000;
  localparam int unsigned TB_PERIOD_10 = 80000;
  localparam int unsigned TB_PERIOD_11 = 200000;

  // beep tones are fixed divisions, specified at this reference oscillator
  localparam int unsigned REF_OSC_HZ  = 8000000;
  localparam int unsigned BEEP_HZ_01  = 2000;
  localparam int unsigned BEEP_HZ_10  = 1000;
  localparam int unsigned BEEP_HZ_11  = 500;
  localparam int unsigned BEEP_HALF_01 = REF_OSC_HZ / (2 * BEEP_HZ_01);
  localparam int unsigned BEEP_HALF_10 = REF_OSC_HZ / (2 * BEEP_HZ_10);
  localparam int unsigned BEEP_HALF_11 = REF_OSC_HZ / (2 * BEEP_HZ_11);

  typedef enum logic [1:0] {
    MCC_RUN,
    MCC_WAIT,
    MCC_ACTIVE_HALT,
    MCC_HALT
  } mcc_mode_t;

  typedef struct packed {
    mcc_mode_t   mode;
    logic [7:0]  ccs;
    logic [1:0]  beepTone;
    logic [1:0]  tbActive;
    logic [17:0] tbCnt;
    logic [12:0] beepCnt;
    logic        beepOut;
    logic        beepOe;
    logic [3:0]  divCnt;
    logic        cpuClkEn;
    logic        clkOut;
    logic        clkOutOe;
    logic        rtcIrq;
    logic        wake;
    logic [1:0]  irqSts;
    logic [1:0]  irqMask;
    logic        irq;
    logic        waitReq;
    logic [7:0]  rdData;
  } mcc_state_t;

  localparam mcc_state_t ST_RESET = '{
    mode: MCC_RUN, ccs: CCS_RESET, beepTone: BEEP_RESET, tbActive: 2'h0,
    tbCnt: 18'h0, beepCnt: 13'h0, beepOut: 1'b0, beepOe: 1'b0, divCnt: 4'h0,
    cpuClkEn: 1'b1, clkOut: 1'b0, clkOutOe: 1'b0, rtcIrq: 1'b0, wake: 1'b0,
    irqSts: 2'h0, irqMask: 2'h0, irq: 1'b0, waitReq: 1'b1, rdData: 8'h00};

  // slow-mode divider as a power of two: 2, 4, 8, 16
  function automatic logic [2:0] slowShift(input logic [1:0] code);
    slowShift = {1'b0, code} + 3'h1;
  endfunction : slowShift

endpackage : mcc_pkg

// *** src/mcc_clock_ctrl.sv ***
`timescale 1ns/1ps
// Contract
// - wait mode leaves the block running; its time-base event ends wait mode when enable bit 1 is set.
// - active halt keeps the time-base counter running, clock and beep registers ignore writes.
// - full halt freezes counter, clock and beep registers until a halt-exit interrupt wakes.
// - cpu interrupt needs the flag, enable bit and cleared global mask.
// - time-base event wakes from active halt, never from full halt.
// - bit 7 routes the cpu clock to its pin; cleared leaves pin free. In normal mode the pin carries half the cpu clock.
// - clock output is suspended during active halt.
// - prescaler codes 00, 01, 11 divide by 2, 4, 16 in slow mode.
// - slow-mode bit 4 cleared gives oscillator clock; set uses prescaler field.
// - time-base codes give 16000, 32000, 80000, 200000 oscillator cycles.
// - new time-base choice applies only when the running period ends.
// - period elapse sets flag bit 0; reading the status register clears it, except in the two halt modes.
// - beep codes give off, ~2 kHz, ~1 kHz, ~500 Hz, half duty.
// - beep keeps running in active halt.
module mcc_clock_ctrl
  import mcc_pkg::*;
#(
  parameter int unsigned TB_CNT_00     = TB_PERIOD_00,
  parameter int unsigned TB_CNT_01     = TB_PERIOD_01,
  parameter int unsigned TB_CNT_10     = TB_PERIOD_10,
  parameter int unsigned TB_CNT_11     = TB_PERIOD_11,
  parameter int unsigned BEEP_CNT_01   = BEEP_HALF_01,
  parameter int unsigned BEEP_CNT_10   = BEEP_HALF_10,
  parameter int unsigned BEEP_CNT_11   = BEEP_HALF_11
)(
  // clock and reset (clk is the oscillator clock)
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [9:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  // cpu side, same clock
  input  wire logic        haltInstr,
  input  wire logic        waitInstr,
  input  wire logic        haltExitWake,
  input  wire logic        globalIntMask,
  output logic             cpuClkEn,
  output logic             rtcIrq,
  output logic             wakeup,
  output mcc_mode_t        powerMode,
  // pins
  output logic             clockOutputPin,
  output logic             clockOutputPinOe,
  output logic             beepPin,
  output logic             beepPinOe,
  // interrupt
  output logic             irq
);

  mcc_state_t st_q;
  mcc_state_t st_d;

  // period end values, cut to the counter widths on purpose
  function automatic logic [17:0] tbLast(input logic [1:0] code);
    unique case (code)
      2'b00: tbLast = 18'(TB_CNT_00 - 1);
      2'b01: tbLast = 18'(TB_CNT_01 - 1);
      2'b10: tbLast = 18'(TB_CNT_10 - 1);
      2'b11: tbLast = 18'(TB_CNT_11 - 1);
    endcase
  endfunction : tbLast

  function automatic logic [12:0] beepLast(input logic [1:0] code);
    unique case (code)
      2'b01: beepLast = 13'(BEEP_CNT_01 - 1);
      2'b10: beepLast = 13'(BEEP_CNT_10 - 1);
      2'b11: beepLast = 13'(BEEP_CNT_11 - 1);
      2'b00: beepLast = 13'h0000;
    endcase
  endfunction : beepLast

  // register read mux, unmapped addresses read zero
  function automatic logic [7:0] regRead(input mcc_state_t s, input logic [9:0] a);
    unique case (a)
      ADDR_CLK_CTRL_STATUS: regRead = s.ccs;
      ADDR_BEEP_CONTROL:    regRead = {6'h00, s.beepTone};
      ADDR_IRQ_STATUS:      regRead = {6'h00, s.irqSts};
      ADDR_IRQ_MASK:        regRead = {6'h00, s.irqMask};
      default:              regRead = 8'h00;
    endcase
  endfunction : regRead

  // next-state logic
  always_comb
  begin
    logic       busReq;
    logic       busAcc;
    logic       frozen;
    logic       running;
    logic       tbEvt;
    logic       osc_interrupt_enable;
    logic       slow_mode_select;
    logic [2:0] shift;
    logic [3:0] divMask;
    busReq  = 1'b0;
    busAcc  = 1'b0;
    frozen  = 1'b0;
    running = 1'b0;
    tbEvt   = 1'b0;
    osc_interrupt_enable     = 1'b0;
    slow_mode_select     = 1'b0;
    shift   = 3'h0;
    divMask = 4'h0;
    st_d    = st_q;
    st_d.wake = 1'b0;

    // bus: one wait cycle, then answer; readdata is prepared during the wait
    busReq = avsRead || avsWrite;
    busAcc = busReq && !st_q.waitReq;
    st_d.waitReq = !(busReq && st_q.waitReq);
    if (busReq && st_q.waitReq)
    begin
      st_d.rdData = regRead(st_q, avsAddress);
    end

    // both halt modes freeze the clock control and beep registers; irq status and mask stay writable
    frozen = (st_q.mode == MCC_ACTIVE_HALT) || (st_q.mode == MCC_HALT);

    // time base keeps counting except in full halt
    if (st_q.mode != MCC_HALT)
    begin
      if (st_q.tbCnt >= tbLast(st_q.tbActive))
      begin
        tbEvt         = 1'b1;
        st_d.tbCnt    = 18'h00000;
        st_d.tbActive = st_q.ccs[CCS_TIME_BASE_LO +: 2];
      end
      else
      begin
        st_d.tbCnt = st_q.tbCnt + 18'h00001;
      end
    end

    // read side effect: clears the timeout flag, unless registers are frozen;
    // only a flag that the read returned is cleared, so one set in the wait cycle survives
    if (busAcc && avsRead && avsAddress == ADDR_CLK_CTRL_STATUS && !frozen
        && st_q.rdData[CCS_OSC_TIMEOUT_FLAG])
    begin
      st_d.ccs[CCS_OSC_TIMEOUT_FLAG] = 1'b0;
    end

    // writes take effect at the accepting edge, low byte lane only
    if (busAcc && avsWrite && avsByteenable[0])
    begin
      unique case (avsAddress)
        ADDR_CLK_CTRL_STATUS:
          if (!frozen)
          begin
            st_d.ccs[7:1] = avsWritedata[7:1]; // flag bit is hardware-set only
          end
        ADDR_BEEP_CONTROL:
          if (!frozen)
          begin
            st_d.beepTone = avsWritedata[BEEP_TONE_LO +: 2]; // reserved bits dropped
          end
        ADDR_IRQ_STATUS:
          st_d.irqSts = st_q.irqSts & ~avsWritedata[1:0];
        ADDR_IRQ_MASK:
          st_d.irqMask = avsWritedata[1:0];
        default:
          st_d.irqMask = st_d.irqMask;
      endcase
    end

    // set wins over a same-cycle read clear
    if (tbEvt)
    begin
      st_d.ccs[CCS_OSC_TIMEOUT_FLAG] = 1'b1;
    end

    // power mode sequencing
    osc_interrupt_enable = st_q.ccs[CCS_OSC_INT_ENABLE];
    unique case (st_q.mode)
      MCC_RUN:
        if (haltInstr)
        begin
          st_d.mode = osc_interrupt_enable ? MCC_ACTIVE_HALT : MCC_HALT;
        end
        else if (waitInstr)
        begin
          st_d.mode = MCC_WAIT;
        end
      MCC_WAIT:
        if (haltExitWake || (tbEvt && osc_interrupt_enable))
        begin
          st_d.mode = MCC_RUN;
          st_d.wake = 1'b1;
        end
      MCC_ACTIVE_HALT:
        if (haltExitWake || (tbEvt && osc_interrupt_enable))
        begin
          st_d.mode = MCC_RUN;
          st_d.wake = 1'b1;
        end
      MCC_HALT:
        if (haltExitWake)
        begin
          st_d.mode = MCC_RUN;
          st_d.wake = 1'b1;
        end
    endcase

    // cpu interrupt request
    st_d.rtcIrq = st_d.ccs[CCS_OSC_TIMEOUT_FLAG] && st_d.ccs[CCS_OSC_INT_ENABLE] && !globalIntMask;

    // sticky event bits, set wins over write-one-to-clear
    if (tbEvt)
    begin
      st_d.irqSts[IRQ_TIME_BASE] = 1'b1;
    end
    if (st_d.wake)
    begin
      st_d.irqSts[IRQ_WAKE] = 1'b1;
    end
    st_d.irq = |(st_d.irqSts & st_d.irqMask);

    // cpu clock: stopped in both halt modes, runs in wait for the peripherals
    running = (st_q.mode == MCC_RUN) || (st_q.mode == MCC_WAIT);
    slow_mode_select     = st_q.ccs[CCS_SLOW_MODE_SELECT];
    shift   = slowShift(st_q.ccs[CCS_SLOW_PRESCALER_LO +: 2]);
    divMask = 4'((5'h01 << shift) - 5'h01);
    if (running)
    begin
      st_d.divCnt = st_q.divCnt + 4'h1;
    end
    st_d.cpuClkEn = running && (!slow_mode_select || ((st_d.divCnt & divMask) == 4'h0));
    // a flop cannot show the undivided clock; normal mode shows half of it
    st_d.clkOut   = running && st_q.ccs[CCS_CLOCK_OUTPUT_SELECT]
                    && (slow_mode_select ? st_d.divCnt[2'(shift - 3'h1)] : st_d.divCnt[0]);
    st_d.clkOutOe = st_q.ccs[CCS_CLOCK_OUTPUT_SELECT];

    // beeper: free division of the oscillator, alive in active halt
    if (st_q.mode != MCC_HALT && st_q.beepTone != 2'b00)
    begin
      if (st_q.beepCnt >= beepLast(st_q.beepTone))
      begin
        st_d.beepCnt = 13'h0000;
        st_d.beepOut = !st_q.beepOut;
      end
      else
      begin
        st_d.beepCnt = st_q.beepCnt + 13'h0001;
      end
    end
    else
    begin
      st_d.beepCnt = 13'h0000;
      st_d.beepOut = 1'b0;
    end
    st_d.beepOe = st_q.beepTone != 2'b00;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= ST_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign avsReaddata      = {24'h000000, st_q.rdData};
  assign avsWaitrequest   = st_q.waitReq;
  assign cpuClkEn         = st_q.cpuClkEn;
  assign rtcIrq           = st_q.rtcIrq;
  assign wakeup           = st_q.wake;
  assign powerMode        = st_q.mode;
  assign clockOutputPin   = st_q.clkOut;
  assign clockOutputPinOe = st_q.clkOutOe;
  assign beepPin          = st_q.beepOut;
  assign beepPinOe        = st_q.beepOe;
  assign irq              = st_q.irq;

endmodule : mcc_clock_ctrl

// *** bench/mcc_cpu_model.sv ***
`timescale 1ns/1ps
module mcc_cpu_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // clock enable seen by the core
  input  wire logic        cpuClkEn,
  output logic      [15:0] tickCnt
);
  // the core only advances on enabled cycles; the bench takes differences
  always_ff @(posedge clk)
    if (sys_rst)
      tickCnt <= 16'h0;
    else if (cpuClkEn)
      tickCnt <= tickCnt + 16'h1;
endmodule : mcc_cpu_model

// *** bench/mcc_clock_ctrl_asserts.sv ***
`timescale 1ns/1ps
module mcc_clock_ctrl_asserts
  import mcc_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register bus
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsReaddata,
  input wire logic        avsWaitrequest,
  // cpu side
  input wire logic        haltInstr,
  input wire logic        haltExitWake,
  input wire logic        globalIntMask,
  input wire logic        cpuClkEn,
  input wire logic        rtcIrq,
  input wire logic        wakeup,
  input wire mcc_mode_t   powerMode,
  // pins
  input wire logic        clockOutputPin,
  input wire logic        beepPin,
  input wire logic        beepPinOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // two cycles of disabled beep, so the pin register has caught up
  sequence beepIdle;
    !beepPinOe [*2];
  endsequence
  sequence haltNoWake;
    powerMode == MCC_HALT && !haltExitWake;
  endsequence
  bus_answer_a: assert property ($rose(avsRead | avsWrite) |=> !avsWaitrequest) else $error("bus not answered");
  bus_stand_a: assert property (!avsWaitrequest |=> avsWaitrequest) else $error("answer held too long");
  bus_upper_a: assert property (!avsWaitrequest |-> avsReaddata[31:8] == 24'h0) else $error("upper data set");
  rtc_mask_a: assert property (rtcIrq |-> !$past(globalIntMask)) else $error("irq while masked");
  halt_hold_a: assert property (haltNoWake |=> powerMode == MCC_HALT) else $error("halt left");
  halt_clk_a: assert property (powerMode inside {MCC_ACTIVE_HALT, MCC_HALT} && $past(powerMode) == powerMode
    |-> !cpuClkEn) else $error("clock in halt");
  clkout_hold_a: assert property (powerMode == MCC_ACTIVE_HALT [*3] |-> $stable(clockOutputPin))
    else $error("clock out runs");
  wake_pulse_a: assert property (wakeup |=> !wakeup) else $error("wake too long");
  halt_entry_a: assert property (haltInstr && powerMode == MCC_RUN && !haltExitWake
    |=> powerMode inside {MCC_ACTIVE_HALT, MCC_HALT}) else $error("halt not entered");
  beep_off_a: assert property (beepIdle |-> !beepPin) else $error("beep while off");
endmodule : mcc_clock_ctrl_asserts

bind mcc_clock_ctrl mcc_clock_ctrl_asserts i_mcc_clock_ctrl_asserts (.clk(clk), .sys_rst(sys_rst),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
  .haltInstr(haltInstr), .haltExitWake(haltExitWake), .globalIntMask(globalIntMask), .cpuClkEn(cpuClkEn),
  .rtcIrq(rtcIrq), .wakeup(wakeup), .powerMode(powerMode), .clockOutputPin(clockOutputPin),
  .beepPin(beepPin), .beepPinOe(beepPinOe));

// *** bench/mcc_clock_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module mcc_clock_ctrl_tb_top
  import mcc_pkg::*;
;
  // bench drives
  logic        clk = 1'b0, sys_rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic        haltI = 1'b0, waitI = 1'b0, hxw = 1'b0, gim = 1'b0;
  logic [9:0]  adr = 10'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'h1;
  logic        cv;
  // design answers
  logic [31:0] rdat;
  logic        wreq, clkEn, rtc, wk, cop, coe, bp, boe, irq;
  mcc_mode_t   pm;
  logic [15:0] ticks, t0c;
  logic [7:0]  q;
  time         tp, ta, tb;
  int          error_cnt = 0, n_checks = 0, seed = 55, pc = 0, c;
  int          codes[4] = '{1, 3, 0, 2};

  always #5 clk = ~clk;

  // short time-base counts keep the run small; the beeper keeps its real divisions
  mcc_clock_ctrl #(.TB_CNT_00(16), .TB_CNT_01(32), .TB_CNT_10(80), .TB_CNT_11(200))
    i_mcc_clock_ctrl (.clk(clk), .sys_rst(sys_rst), .avsAddress(adr),
    .avsRead(rd), .avsWrite(wr), .avsWritedata(wdat), .avsByteenable(be), .avsReaddata(rdat),
    .avsWaitrequest(wreq), .haltInstr(haltI), .waitInstr(waitI), .haltExitWake(hxw), .globalIntMask(gim),
    .cpuClkEn(clkEn), .rtcIrq(rtc), .wakeup(wk), .powerMode(pm), .clockOutputPin(cop),
    .clockOutputPinOe(coe), .beepPin(bp), .beepPinOe(boe), .irq(irq));
  mcc_cpu_model i_mcc_cpu_model (.clk(clk), .sys_rst(sys_rst), .cpuClkEn(clkEn), .tickCnt(ticks));

  // expected spans in ns
  function automatic time per(input int k);
    return (k == 0 ? 16 : k == 1 ? 32 : k == 2 ? 80 : 200) * 10;
  endfunction : per
  function automatic time beepHalf(input int k);
    return (k == 1 ? BEEP_HALF_01 : k == 2 ? BEEP_HALF_10 : BEEP_HALF_11) * 10;
  endfunction : beepHalf

  // request held until waitrequest is sampled low; upper lanes carry noise
  task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {24'($random(seed)), d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic clr;
    bus(ADDR_IRQ_STATUS, 1'b1, 8'h01);
    repeat (2) @(posedge clk);
  endtask : clr
  task automatic wait_irq(output time t);
    while (irq !== 1'b1) @(posedge clk);
    t = $time;
  endtask : wait_irq
  task automatic bp_edge(output time t);
    logic w;
    w = bp;
    while (bp === w) @(posedge clk);
    t = $time;
  endtask : bp_edge
  // 0 halt, 1 wait, 2 halt-exit interrupt
  task automatic cpu_op(input int k);
    @(posedge clk);
    haltI <= (k == 0);
    waitI <= (k == 1);
    hxw <= (k == 2);
    @(posedge clk);
    haltI <= 1'b0;
    waitI <= 1'b0;
    hxw <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : cpu_op
  task automatic report_and_stop;
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // about fifty thousand cycles are needed, mostly beep tones; eighty thousand means a hang
  initial
  begin
    #800000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    bus(ADDR_CLK_CTRL_STATUS, 1'b0, 8'h00);
    `CHK(q, CCS_RESET)
    bus(ADDR_BEEP_CONTROL, 1'b0, 8'h00);
    `CHK(q, 8'h00)
    bus(10'h3f0, 1'b1, 8'hff);
    bus(10'h3f0, 1'b0, 8'h00);
    `CHK(q, 8'h00)
    // a write without the low byte lane is ignored
    be <= 4'h0;
    bus(ADDR_BEEP_CONTROL, 1'b1, 8'h03);
    be <= 4'h1;
    bus(ADDR_BEEP_CONTROL, 1'b0, 8'h00);
    `CHK(q, 8'h00)
    // periods per code; a change mid-period lands at its end
    bus(ADDR_IRQ_MASK, 1'b1, 8'h01);
    clr();
    wait_irq(tp);
    foreach (codes[i])
    begin
      c = codes[i];
      bus(ADDR_CLK_CTRL_STATUS, 1'b1, {4'h0, 2'(c), 2'b00});
      clr();
      wait_irq(ta);
      `CHK(ta - tp, per(pc))
      clr();
      wait_irq(tb);
      `CHK(tb - ta, per(c))
      tp = tb;
      pc = c;
    end
    // masked event stays pending, unmasking raises the line
    bus(ADDR_IRQ_MASK, 1'b1, 8'h00);
    clr();
    repeat (100) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(ADDR_IRQ_MASK, 1'b1, 8'h01);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    // flag, enable and global mask
    gim <= 1'b1;
    bus(ADDR_CLK_CTRL_STATUS, 1'b1, 8'h0a);
    clr();
    wait_irq(ta);
    repeat (2) @(posedge clk);
    `CHK(rtc, 1'b0)
    bus(ADDR_CLK_CTRL_STATUS, 1'b0, 8'h00);
    `CHK(q, 8'h0b)
    bus(ADDR_CLK_CTRL_STATUS, 1'b0, 8'h00);
    `CHK(q, 8'h0a)
    gim <= 1'b0;
    clr();
    wait_irq(ta);
    repeat (2) @(posedge clk);
    `CHK(rtc, 1'b1)
    // active halt: writes frozen, time base wakes
    cpu_op(0);
    `CHK(pm, MCC_ACTIVE_HALT)
    bus(ADDR_CLK_CTRL_STATUS, 1'b1, 8'h00);
    while (pm !== MCC_RUN) @(posedge clk);
    bus(ADDR_CLK_CTRL_STATUS, 1'b0, 8'h00);
    `CHK(q & 8'hfe, 8'h0a)
    // full halt ignores time base and writes
    bus(ADDR_CLK_CTRL_STATUS, 1'b1, 8'h00);
    cpu_op(0);
    `CHK(pm, MCC_HALT)
    bus(ADDR_CLK_CTRL_STATUS, 1'b1, 8'h80);
    repeat (60) @(posedge clk);
    `CHK(pm, MCC_HALT)
    `CHK(clkEn, 1'b0)
    cpu_op(2);
    `CHK(pm, MCC_RUN)
    bus(ADDR_CLK_CTRL_STATUS, 1'b0, 8'h00);
    `CHK(q & 8'hfe, 8'h00)
    bus(ADDR_CLK_CTRL_STATUS, 1'b1, 8'h0e);
    // align to a period end so no event wakes before the mode check
    clr();
    wait_irq(ta);
    cpu_op(1);
    `CHK(pm, MCC_WAIT)
    while (pm !== MCC_RUN) @(posedge clk);
    // slow mode divisions, then normal mode
    for (int k = 0; k < 5; k++)
    begin
      bus(ADDR_CLK_CTRL_STATUS, 1'b1, k < 4 ? {1'b0, 2'(k), 5'h10} : 8'h00);
      repeat (4) @(posedge clk);
      t0c = ticks;
      repeat (64) @(posedge clk);
      `CHK(16'(ticks - t0c), 16'(k < 4 ? 32 >> k : 64))
    end
    bus(ADDR_CLK_CTRL_STATUS, 1'b1, 8'h80);
    repeat (2) @(posedge clk);
    `CHK(coe, 1'b1)
    cv = cop;
    @(posedge clk);
    `CHK(cop, !cv)
    bus(ADDR_CLK_CTRL_STATUS, 1'b1, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(coe, 1'b0)
    // every tone, then one drawn at random; tone off drops pin and enable
    for (int k = 1; k < 5; k++)
    begin
      c = k < 4 ? k : 1 + $unsigned($random(seed)) % 3;
      bus(ADDR_BEEP_CONTROL, 1'b1, 8'(c));
      bp_edge(ta);
      bp_edge(tb);
      `CHK(tb - ta, beepHalf(c))
    end
    bus(ADDR_BEEP_CONTROL, 1'b1, 8'h00);
    repeat (3) @(posedge clk);
    `CHK({boe, bp}, 2'b00)
    report_and_stop();
  end
endmodule : mcc_clock_ctrl_tb_top
